// >>> hdl/clc_pkg.sv
package clc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets within the local register window
    localparam logic [7:0] OFF_ALL_RESET  = 8'h88;
    localparam logic [7:0] OFF_MOD_IRQ_EN = 8'hA0;
    localparam logic [7:0] OFF_STB_IRQ_EN = 8'hA2;
    localparam logic [7:0] OFF_DMA_IRQ_EN = 8'hA6;
    localparam logic [7:0] OFF_SITE_A_RST = 8'hA8;
    localparam logic [7:0] OFF_SITE_B_RST = 8'hAA;
    localparam logic [7:0] OFF_DMA_STATUS = 8'hAE;
    localparam logic [7:0] OFF_CLK_CTRL   = 8'hC0;
    localparam logic [7:0] OFF_ERR        = 8'hC2;
    localparam logic [7:0] OFF_STB_SRC    = 8'hD0;
    localparam logic [7:0] OFF_HOST_BITS  = 8'hD6;
    localparam logic [7:0] OFF_TRIG_SRC   = 8'hD8;

    // Field positions
    localparam int MASTER_BIT     = 2;
    localparam int CLK_A_BIT      = 4;
    localparam int CLK_B_BIT      = 5;
    localparam int ERR_BIT        = 0;
    localparam int GATE_EN_A_BIT  = 4;
    localparam int GATE_EN_B_BIT  = 5;
    localparam int TRIG0_STAT_BIT = 3;
    localparam int TRIG1_STAT_BIT = 7;
    localparam logic [7:0] STB_EN_MASK = 8'h73;

    // Values after reset
    localparam logic [7:0] REG_RST_VAL = 8'h00;

    // Module reset pulse timing
    localparam int RST_PULSE_NS  = 1000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RST_CYC_INT   = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] RST_CYC = 4'(RST_CYC_INT);

    // Strobe source select codes
    localparam logic [3:0] STB_SEL_HOST0 = 4'h4;
    localparam logic [3:0] STB_SEL_IRQ_LO = 4'h5;
    localparam logic [3:0] STB_SEL_IRQ_HI = 4'h8;
    localparam logic [3:0] STB_SEL_CLK8  = 4'hD;
    localparam logic [3:0] STB_SEL_TRIG0 = 4'hE;
    localparam logic [3:0] STB_SEL_TRIG1 = 4'hF;

    // Trigger source codes
    localparam logic [2:0] TRG_GND     = 3'h0;
    localparam logic [2:0] TRG_HOST_LO = 3'h1;
    localparam logic [2:0] TRG_STROBE  = 3'h2;
    localparam logic [2:0] TRG_A_IRQ0  = 3'h3;
    localparam logic [2:0] TRG_B_IRQ0  = 3'h4;
    localparam logic [2:0] TRG_HOST_HI = 3'h7;

    // Layout of the synchronised pin vector
    localparam int SYNC_W    = 18;
    localparam int S_REQ     = 0;
    localparam int S_DMA     = 4;
    localparam int S_STB     = 8;
    localparam int S_BFAULT  = 12;
    localparam int S_TRIG    = 13;
    localparam int S_ERR     = 15;
    localparam int S_CLK8    = 17;

    typedef struct packed {
        logic [3:0]  mod_en;
        logic [7:0]  stb_en;
        logic [3:0]  dma_en;
        logic        clk_a_fast;
        logic        clk_b_fast;
        logic        master_en;
        logic        err;
        logic [3:0]  stb_sel;
        logic        gate_a;
        logic        gate_b;
        logic [3:0]  host;
        logic [2:0]  trig0_code;
        logic [2:0]  trig1_code;
        logic [3:0]  rst_a_cnt;
        logic [3:0]  rst_b_cnt;
        logic [15:0] rdata;
        logic        rvalid;
        logic        site_a_rst;
        logic        site_b_rst;
        logic        irq_n;
        logic        stb_out;
        logic        stb_a_oe_n;
        logic        stb_b_oe_n;
        logic [1:0]  trig_out;
        logic [1:0]  trig_oe_n;
    } clc_state_t;

    localparam clc_state_t CLC_ST_RST = '{irq_n: 1'b1, stb_a_oe_n: 1'b1, stb_b_oe_n: 1'b1,
                                          trig_oe_n: 2'h3, default: '0};

    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] q;
    } clc_sync_t;

endpackage

// >>> hdl/clc_sync.sv
`timescale 1ns/1ps
module clc_sync
    import clc_pkg::*;
(
    input  wire logic              i_mclk,  // Local bus clock
    input  wire logic              i_rst,   // Synchronous reset
    input  wire logic [SYNC_W-1:0] i_d,     // Pin levels, asynchronous
    output logic      [SYNC_W-1:0] o_q      // Synchronised levels
);
    clc_sync_t st;
    clc_sync_t next_st;

    // First stage feeds only the second stage
    always_comb
    begin
        next_st.meta = i_d;
        next_st.q    = st.meta;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_q = st.q;
endmodule

// >>> hdl/clc_regs.sv
//
// Function
// - Global reset write pulses both site resets
// - Clock bits 4/5 pick 32 MHz per site
// - Bit 2 master-gates the local interrupt
// - Module error captured in sticky latch
// - Error bit 0 reads low when latched
// - Any write to error register clears latch, unless a synchronised module error is set that same cycle
// - Module request enables gate interrupt line
// - Site A reset read gives request levels
// - Strobe, fault, trigger enables gate interrupt
// - Site B reset read gives strobe/trigger levels
// - DMA request enables gate interrupt line
// - DMA status read gives request levels
// - Site A/B reset writes hit one site
// - Four-bit select picks strobe source
// - Bits 4/5 enable site strobe outputs
// - Host register holds four static bits
// - Trigger nibbles select per-line sources
// - Nonzero trigger code drives line out
// - Trigger register bits 3/7 show lines
`timescale 1ns/1ps
module clc_regs
    import clc_pkg::*;
(
    input  wire logic                i_mclk,                    // Local bus clock, 10 MHz
    input  wire logic                i_rst,                     // Synchronous reset, active high
    input  wire logic [ADDR_W-1:0]   i_addr,                    // Register byte offset
    input  wire logic                i_wr,                      // Write strobe, one cycle
    input  wire logic                i_rd,                      // Read strobe, one cycle
    input  wire logic [DATA_W-1:0]   i_wdata,                   // Write data, low byte used
    input  wire logic [3:0]          i_site_request,            // Module interrupt requests
    input  wire logic [3:0]          i_site_dma_req,            // Module DMA requests
    input  wire logic [3:0]          i_strobe_in,               // Strobe line levels A..D
    input  wire logic                i_bus_fault,               // Bus error level
    input  wire logic [1:0]          i_trig_in,                 // Trigger line levels
    input  wire logic [1:0]          i_module_error,            // Error from site A, B
    input  wire logic                i_clk8_ref,                // 8 MHz module clock
    output logic      [DATA_W-1:0]   o_rdata,                   // Read data
    output logic                     o_rvalid,                  // Read data valid pulse
    output logic                     o_site_a_reset,            // Site A module reset
    output logic                     o_site_b_reset,            // Site B module reset
    output logic                     o_site_a_clk_fast,         // Site A 32 MHz select
    output logic                     o_site_b_clk_fast,         // Site B 32 MHz select
    output logic                     o_local_interrupt_line_n,  // Interrupt to bridge, low active
    output logic                     o_strobe_out,              // Selected strobe source
    output logic                     o_strobe_a_oe_n,           // Site A strobe drive, low active
    output logic                     o_strobe_b_oe_n,           // Site B strobe drive, low active
    output logic      [1:0]          o_trig_out,                // Trigger line drive value
    output logic      [1:0]          o_trig_oe_n                // Trigger drive, low active
);
    import clc_pkg::*;

    clc_state_t        st;
    clc_state_t        next_st;
    logic [SYNC_W-1:0] pins;
    logic [7:0]        rd_val;
    logic [3:0]        req_s;
    logic [3:0]        dma_s;
    logic [3:0]        stb_s;
    logic              bfault_s;
    logic [1:0]        trig_s;
    logic [1:0]        err_s;
    logic              clk8_s;
    logic [7:0]        stb_status;
    logic              stb_src;
    logic              any_irq;

    clc_sync u_sync (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_d    ({i_clk8_ref, i_module_error, i_trig_in, i_bus_fault,
                  i_strobe_in, i_site_dma_req, i_site_request}),
        .o_q    (pins)
    );

    assign req_s    = pins[S_REQ +: 4];
    assign dma_s    = pins[S_DMA +: 4];
    assign stb_s    = pins[S_STB +: 4];
    assign bfault_s = pins[S_BFAULT];
    assign trig_s   = pins[S_TRIG +: 2];
    assign err_s    = pins[S_ERR +: 2];
    // Sampled at 10 MHz, so the 8 MHz reference aliases; use only as a coarse source
    assign clk8_s   = pins[S_CLK8];

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic strobe_mux(
        input logic [3:0] sel,
        input logic [3:0] stb,
        input logic       host0,
        input logic [3:0] req,
        input logic       clk8,
        input logic [1:0] trig
    );
        strobe_mux = 1'b0;
        if (sel < STB_SEL_HOST0)
            strobe_mux = stb[sel[1:0]];
        else if (sel == STB_SEL_HOST0)
            strobe_mux = host0;
        else if (sel >= STB_SEL_IRQ_LO && sel <= STB_SEL_IRQ_HI)
            strobe_mux = req[2'(sel - STB_SEL_IRQ_LO)];
        else if (sel == STB_SEL_CLK8)
            strobe_mux = clk8;
        else if (sel == STB_SEL_TRIG0)
            strobe_mux = trig[0];
        else if (sel == STB_SEL_TRIG1)
            strobe_mux = trig[1];
    endfunction

    function automatic logic trig_mux(
        input logic [2:0] code,
        input logic       host_lo,
        input logic       host_hi,
        input logic       stb,
        input logic [3:0] req
    );
        case (code)
            TRG_HOST_LO: trig_mux = host_lo;
            TRG_STROBE:  trig_mux = stb;
            TRG_A_IRQ0:  trig_mux = req[0];
            TRG_B_IRQ0:  trig_mux = req[2];
            TRG_HOST_HI: trig_mux = host_hi;
            default:     trig_mux = 1'b0;
        endcase
    endfunction

    // Live levels in the strobe-enable bit layout
    assign stb_status = {1'b0, trig_s, bfault_s, 2'b00, stb_s[1:0]};
    assign stb_src    = strobe_mux(st.stb_sel, stb_s, st.host[0], req_s, clk8_s, trig_s);

    assign any_irq = (|(st.mod_en & req_s))
                   | (|(st.stb_en & stb_status & STB_EN_MASK))
                   | (|(st.dma_en & dma_s));

    always_comb
    begin
        next_st = st;
        rd_val  = 8'h00;

        case (i_addr)
            OFF_MOD_IRQ_EN: rd_val = {4'h0, st.mod_en};
            OFF_STB_IRQ_EN: rd_val = st.stb_en;
            OFF_DMA_IRQ_EN: rd_val = {4'h0, st.dma_en};
            OFF_SITE_A_RST: rd_val = {4'h0, req_s};
            OFF_SITE_B_RST: rd_val = stb_status;
            OFF_DMA_STATUS: rd_val = {4'h0, dma_s};
            OFF_CLK_CTRL:   rd_val = {2'b00, st.clk_b_fast, st.clk_a_fast, 1'b0, st.master_en, 2'b00};
            OFF_ERR:        rd_val = {7'h00, ~st.err};
            OFF_STB_SRC:    rd_val = {2'b00, st.gate_b, st.gate_a, st.stb_sel};
            OFF_HOST_BITS:  rd_val = {4'h0, st.host};
            OFF_TRIG_SRC:   rd_val = {trig_s[1], st.trig1_code, trig_s[0], st.trig0_code};
            default:        rd_val = 8'h00;
        endcase

        next_st.rvalid = i_rd;
        if (i_rd)
            next_st.rdata = {8'h00, rd_val};

        // Reset pulses run down on their own
        if (st.rst_a_cnt != 4'h0)
            next_st.rst_a_cnt = st.rst_a_cnt - 4'h1;
        if (st.rst_b_cnt != 4'h0)
            next_st.rst_b_cnt = st.rst_b_cnt - 4'h1;

        if (i_wr)
        begin
            if (hit(i_addr, OFF_ALL_RESET))
            begin
                next_st.rst_a_cnt = RST_CYC;
                next_st.rst_b_cnt = RST_CYC;
            end
            if (hit(i_addr, OFF_SITE_A_RST))
                next_st.rst_a_cnt = RST_CYC;
            if (hit(i_addr, OFF_SITE_B_RST))
                next_st.rst_b_cnt = RST_CYC;
            if (hit(i_addr, OFF_MOD_IRQ_EN))
                next_st.mod_en = i_wdata[3:0];
            if (hit(i_addr, OFF_STB_IRQ_EN))
                next_st.stb_en = i_wdata[7:0] & STB_EN_MASK;
            if (hit(i_addr, OFF_DMA_IRQ_EN))
                next_st.dma_en = i_wdata[3:0];
            if (hit(i_addr, OFF_CLK_CTRL))
            begin
                next_st.clk_a_fast = i_wdata[CLK_A_BIT];
                next_st.clk_b_fast = i_wdata[CLK_B_BIT];
                next_st.master_en  = i_wdata[MASTER_BIT];
            end
            if (hit(i_addr, OFF_ERR))
                next_st.err = 1'b0;
            if (hit(i_addr, OFF_STB_SRC))
            begin
                next_st.stb_sel = i_wdata[3:0];
                next_st.gate_a  = i_wdata[GATE_EN_A_BIT];
                next_st.gate_b  = i_wdata[GATE_EN_B_BIT];
            end
            if (hit(i_addr, OFF_HOST_BITS))
                next_st.host = i_wdata[3:0];
            if (hit(i_addr, OFF_TRIG_SRC))
            begin
                next_st.trig0_code = i_wdata[2:0];
                next_st.trig1_code = i_wdata[6:4];
            end
        end

        // Set beats a clear in the same cycle so no error is lost
        if (|err_s)
            next_st.err = 1'b1;

        next_st.site_a_rst = (next_st.rst_a_cnt != 4'h0);
        next_st.site_b_rst = (next_st.rst_b_cnt != 4'h0);

        next_st.irq_n = ~(st.master_en & any_irq);

        next_st.stb_out    = stb_src;
        next_st.stb_a_oe_n = ~st.gate_a;
        next_st.stb_b_oe_n = ~st.gate_b;

        next_st.trig_out[0]  = trig_mux(st.trig0_code, st.host[0], st.host[2], stb_src, req_s);
        next_st.trig_out[1]  = trig_mux(st.trig1_code, st.host[1], st.host[3], stb_src, req_s);
        next_st.trig_oe_n[0] = (st.trig0_code == TRG_GND);
        next_st.trig_oe_n[1] = (st.trig1_code == TRG_GND);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            st <= CLC_ST_RST;
        else
            st <= next_st;
    end

    assign o_rdata                  = st.rdata;
    assign o_rvalid                 = st.rvalid;
    assign o_site_a_reset           = st.site_a_rst;
    assign o_site_b_reset           = st.site_b_rst;
    assign o_site_a_clk_fast        = st.clk_a_fast;
    assign o_site_b_clk_fast        = st.clk_b_fast;
    assign o_local_interrupt_line_n = st.irq_n;
    assign o_strobe_out             = st.stb_out;
    assign o_strobe_a_oe_n          = st.stb_a_oe_n;
    assign o_strobe_b_oe_n          = st.stb_b_oe_n;
    assign o_trig_out               = st.trig_out;
    assign o_trig_oe_n              = st.trig_oe_n;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    property p_all_reset;
        (i_wr && i_addr == OFF_ALL_RESET) |=> (o_site_a_reset && o_site_b_reset);
    endproperty
    a_all_reset: assert property (p_all_reset) else $error("global reset did not reach both sites");

    property p_clk_sel;
        (i_wr && i_addr == OFF_CLK_CTRL) |=> (o_site_a_clk_fast == $past(i_wdata[4])
                                           && o_site_b_clk_fast == $past(i_wdata[5]));
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock select bits not taken");

    property p_master;
        !st.master_en |=> o_local_interrupt_line_n;
    endproperty
    a_master: assert property (p_master) else $error("interrupt asserted with master disabled");

    property p_mod_irq;
        (st.master_en && (|(st.mod_en & req_s))) |=> !o_local_interrupt_line_n;
    endproperty
    a_mod_irq: assert property (p_mod_irq) else $error("enabled module request missed");

    property p_err_set;
        ((|err_s) || (st.err && !(i_wr && i_addr == OFF_ERR))) |=> st.err;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error latch not sticky");

    property p_err_read;
        (i_rd && i_addr == OFF_ERR) |=> (o_rdata[0] == !$past(st.err) && o_rdata[15:1] == 15'h0000);
    endproperty
    a_err_read: assert property (p_err_read) else $error("error bit read wrong");

    property p_err_clr;
        (i_wr && i_addr == OFF_ERR && !(|err_s)) |=> !st.err;
    endproperty
    a_err_clr: assert property (p_err_clr) else $error("error latch not cleared");

    property p_req_read;
        (i_rd && i_addr == OFF_SITE_A_RST) |=> (o_rvalid && o_rdata[3:0] == $past(req_s));
    endproperty
    a_req_read: assert property (p_req_read) else $error("request status read wrong");

    property p_dma_read;
        (i_rd && i_addr == OFF_DMA_STATUS) |=> (o_rdata[7:0] == {4'h0, $past(dma_s)});
    endproperty
    a_dma_read: assert property (p_dma_read) else $error("dma status read wrong");

    property p_site_a_only;
        (i_wr && i_addr == OFF_SITE_A_RST && !o_site_b_reset && st.rst_b_cnt == 4'h0) |=> !o_site_b_reset;
    endproperty
    a_site_a_only: assert property (p_site_a_only) else $error("site A reset hit site B");

    property p_pulse_len;
        $rose(o_site_a_reset) |-> o_site_a_reset [*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("site reset pulse too short");

    // Cycles since the last write that restarted the site B pulse; saturates
    logic [4:0] b_quiet;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            b_quiet <= 5'h1F;
        else if (i_wr && (hit(i_addr, OFF_ALL_RESET) || hit(i_addr, OFF_SITE_B_RST)))
            b_quiet <= 5'h00;
        else if (b_quiet != 5'h1F)
            b_quiet <= b_quiet + 5'h01;
    end

    property p_pulse_end;
        (b_quiet >= 5'(RST_CYC_INT)) |-> !o_site_b_reset;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("site reset pulse did not end");

    property p_strobe_host;
        (st.gate_a && st.stb_sel == STB_SEL_HOST0) |=> (!o_strobe_a_oe_n && o_strobe_out == $past(st.host[0]));
    endproperty
    a_strobe_host: assert property (p_strobe_host) else $error("strobe output not host bit");

    property p_trig_gnd;
        (st.trig0_code == TRG_GND) |=> o_trig_oe_n[0];
    endproperty
    a_trig_gnd: assert property (p_trig_gnd) else $error("trigger driven with ground code");

    property p_trig_read;
        (i_rd && i_addr == OFF_TRIG_SRC) |=> (o_rdata[3] == $past(trig_s[0]) && o_rdata[7] == $past(trig_s[1]));
    endproperty
    a_trig_read: assert property (p_trig_read) else $error("trigger line status read wrong");

    property p_host_read;
        (i_rd && i_addr == OFF_HOST_BITS) |=> (o_rdata[15:4] == 12'h000);
    endproperty
    a_host_read: assert property (p_host_read) else $error("unused host bits not zero");

endmodule

// >>> verification/clc_bridge_model.sv
`timescale 1ns/1ps
module clc_bridge_model
    import clc_pkg::*;
(
    input  wire logic              i_mclk,   // Local bus clock
    input  wire logic [DATA_W-1:0] i_rdata,  // Read data from block
    input  wire logic              i_rvalid, // Read answer pulse
    output logic      [ADDR_W-1:0] o_addr,   // Register offset
    output logic                   o_wr,     // Write strobe
    output logic                   o_rd,     // Read strobe
    output logic      [DATA_W-1:0] o_wdata   // Write data
);
    initial
    begin
        o_addr  = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 16'h0000;
    end

    // Released lines go inverted so a stale value never passes for a held one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_addr  = a;
        o_wdata = {8'h00, d};
        o_wr    = 1'b1;
        @(negedge i_mclk);
        o_wr    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~{8'h00, d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        d  = 16'h0000;
        ok = 1'b0;
        @(negedge i_mclk);
        o_addr = a;
        o_rd   = 1'b1;
        @(negedge i_mclk);
        o_rd   = 1'b0;
        o_addr = ~a;
        for (int k = 0; k < 3 && !ok; k++)
        begin
            if (i_rvalid === 1'b1)
            begin
                d  = i_rdata;
                ok = 1'b1;
            end
            else
                @(negedge i_mclk);
        end
    endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import clc_pkg::*;
    logic        clk, rst, wr, rd, bf, clk8, rvalid, rst_a, rst_b, fast_a, fast_b, irq_n, stb_out, oe_a_n, oe_b_n;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata;
    logic [3:0]  req, dma, stb;
    logic [1:0]  trg, err, trig_out, trig_oe_n;
    int          bad_count, n_compared;

    clc_regs clc_regs_i (.i_mclk(clk), .i_rst(rst), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
        .i_site_request(req), .i_site_dma_req(dma), .i_strobe_in(stb), .i_bus_fault(bf), .i_trig_in(trg),
        .i_module_error(err), .i_clk8_ref(clk8), .o_rdata(rdata), .o_rvalid(rvalid), .o_site_a_reset(rst_a),
        .o_site_b_reset(rst_b), .o_site_a_clk_fast(fast_a), .o_site_b_clk_fast(fast_b),
        .o_local_interrupt_line_n(irq_n), .o_strobe_out(stb_out), .o_strobe_a_oe_n(oe_a_n),
        .o_strobe_b_oe_n(oe_b_n), .o_trig_out(trig_out), .o_trig_oe_n(trig_oe_n));
    clc_bridge_model clc_bridge_model_i (.i_mclk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
        .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

    always #50 clk = ~clk;

    task automatic summarize();
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("ERROR %0t got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        clc_bridge_model_i.rd(a, d, ok);
        if (!ok)
        begin
            $display("ERROR %0t read not answered", $time);
            bad_count++;
            summarize();
        end
        else
            chk(d, exp);
    endtask
    task automatic wrs(input logic [7:0] a, input logic [7:0] d);
        clc_bridge_model_i.wr(a, d);
        repeat (4) @(negedge clk);
    endtask

    task automatic t_regs();
        logic [7:0] offs [8] = '{OFF_MOD_IRQ_EN, OFF_STB_IRQ_EN, OFF_DMA_IRQ_EN, OFF_CLK_CTRL, OFF_STB_SRC,
                                 OFF_HOST_BITS, OFF_TRIG_SRC, 8'h90};
        logic [7:0] expv [8] = '{8'h0F, STB_EN_MASK, 8'h0F, 8'h34, 8'h3F, 8'h0F, 8'h77, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            rdc(offs[i], {8'h00, REG_RST_VAL});
            wrs(offs[i], 8'hFF);
            rdc(offs[i], {8'h00, expv[i]});
            wrs(offs[i], 8'h00);
        end
        rdc(OFF_ALL_RESET, 16'h0000);
        wrs(OFF_CLK_CTRL, 8'h10);
        chk({14'h0, fast_a, fast_b}, 16'h0002);
        wrs(OFF_CLK_CTRL, 8'h20);
        chk({14'h0, fast_a, fast_b}, 16'h0001);
    endtask
    task automatic t_rst(input logic [7:0] a, input logic [1:0] exp);
        int n;
        n = 0;
        clc_bridge_model_i.wr(a, 8'h5A);
        chk({14'h0, rst_a, rst_b}, {14'h0, exp});
        while ((rst_a | rst_b) === 1'b1 && n < 20)
        begin
            n++;
            @(negedge clk);
        end
        chk(16'(n), 16'(RST_CYC_INT));
    endtask
    task automatic t_status();
        req = 4'h5;
        dma = 4'hA;
        stb = 4'hE;
        bf  = 1'b1;
        trg = 2'b01;
        repeat (4) @(negedge clk);
        rdc(OFF_SITE_A_RST, 16'h0005);
        rdc(OFF_DMA_STATUS, 16'h000A);
        rdc(OFF_SITE_B_RST, 16'h0032);
        rdc(OFF_TRIG_SRC, 16'h0008);
    endtask
    task automatic t_err();
        err = 2'b10;
        repeat (4) @(negedge clk);
        err = 2'b00;
        repeat (4) @(negedge clk);
        rdc(OFF_ERR, 16'h0000);
        wrs(OFF_ERR, 8'hA5);
        rdc(OFF_ERR, 16'h0001);
    endtask
    task automatic t_irq();
        // Columns: clock control, module, strobe, dma enables, expected line
        logic [39:0] tab [8] = '{40'h00_01_00_00_01, 40'h04_01_00_00_00, 40'h04_02_00_00_01,
            40'h04_00_10_00_00, 40'h04_00_01_00_01, 40'h04_00_00_02_00, 40'h04_00_00_01_01,
            40'h04_00_20_00_00};
        for (int i = 0; i < 8; i++)
        begin
            clc_bridge_model_i.wr(OFF_CLK_CTRL, tab[i][39:32]);
            clc_bridge_model_i.wr(OFF_MOD_IRQ_EN, tab[i][31:24]);
            clc_bridge_model_i.wr(OFF_STB_IRQ_EN, tab[i][23:16]);
            wrs(OFF_DMA_IRQ_EN, tab[i][15:8]);
            chk({15'h0, irq_n}, {15'h0, tab[i][0]});
        end
    endtask
    task automatic t_mux();
        logic [15:0] e;
        clk8 = 1'b1;
        wrs(OFF_HOST_BITS, 8'h05);
        e = {trg, clk8, 4'h0, req, 1'b1, stb};
        for (int s = 0; s < 16; s++)
        begin
            wrs(OFF_STB_SRC, 8'h10 | 8'(s));
            chk({13'h0, stb_out, oe_a_n, oe_b_n}, {13'h0, e[s], 2'b01});
        end
        wrs(OFF_STB_SRC, 8'h24);
        chk({13'h0, stb_out, oe_a_n, oe_b_n}, 16'h0006);
    endtask
    task automatic t_trig();
        logic [7:0] s0, s1;
        s0 = 8'b1001_1110;
        s1 = 8'b0001_1100;
        for (int c = 0; c < 8; c++)
        begin
            wrs(OFF_TRIG_SRC, {1'b0, 3'(c), 1'b0, 3'(c)});
            chk({12'h0, trig_out, trig_oe_n}, {12'h0, s1[c], s0[c], (c == 0) ? 2'b11 : 2'b00});
        end
    endtask

    initial
    begin
        repeat (30000) @(posedge clk);
        $display("ERROR %0t run did not finish", $time);
        bad_count++;
        summarize();
    end

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        {req, dma, stb, bf, trg, err, clk8} = '0;
        bad_count = 0;
        n_compared = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_rst(OFF_ALL_RESET, 2'b11);
        t_rst(OFF_SITE_A_RST, 2'b10);
        t_rst(OFF_SITE_B_RST, 2'b01);
        t_status();
        t_err();
        t_irq();
        t_mux();
        t_trig();
        summarize();
    end
endmodule
